// ### verilog/ptc_pkg.sv
// Package with register map, field layout, reset values and divide ratios of the periodic tick counter.
`default_nettype none
package ptc_pkg;
    // Byte addresses of the registers on the 32-bit bus.
    localparam logic [3:0]  PTC_STATUS_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0]  PTC_COUNT_OFFSET          = 4'h4;
    localparam logic [3:0]  PTC_LIMIT_OFFSET          = 4'h8;
    // Field positions in tick_status_control.
    localparam int          PTC_FLAG_BIT     = 7;
    localparam int          PTC_SRC_HI_BIT   = 6;
    localparam int          PTC_SRC_LO_BIT   = 5;
    localparam int          PTC_IRQ_EN_BIT   = 4;
    localparam int          PTC_DIV_HI_BIT   = 3;
    // Values after reset.
    localparam logic [7:0]  PTC_COUNT_RESET  = 8'h00;
    localparam logic [7:0]  PTC_LIMIT_RESET  = 8'h00;
    localparam logic [1:0]  PTC_SRC_RESET    = 2'h0;
    localparam logic [3:0]  PTC_DIV_RESET    = 4'h0;
    localparam logic [3:0]  PTC_DIV_OFF      = 4'h0;
    localparam logic [17:0] PTC_PRESCALE_RESET = 18'h00000;
    // Source select codes; the high bit set always picks the internal clock.
    localparam logic [1:0]  PTC_SRC_LOW_POWER = 2'h0;
    localparam logic [1:0]  PTC_SRC_EXTERNAL  = 2'h1;
    localparam int          PTC_SYNC_STAGES   = 3;
    // Divide ratios indexed by divider select, entry 0 unused because the prescaler is off.
    localparam logic [15:0][17:0] PTC_RATIO_SRC_LO0 = {
        18'h003e8, 18'h001f4, 18'h00064, 18'h00010, 18'h0000a, 18'h00004, 18'h00002, 18'h00001,
        18'h00400, 18'h00200, 18'h00100, 18'h00080, 18'h00040, 18'h00020, 18'h00008, 18'h00001};
    localparam logic [15:0][17:0] PTC_RATIO_SRC_LO1 = {
        18'h30d40, 18'h186a0, 18'h0c350, 18'h04e20, 18'h02710, 18'h01388, 18'h007d0, 18'h003e8,
        18'h10000, 18'h08000, 18'h04000, 18'h02000, 18'h01000, 18'h00800, 18'h00400, 18'h00001};

    typedef struct packed {
        logic       flag;
        logic [1:0] srcSel;
        logic       irqEnable;
        logic [3:0] divSel;
    } ptc_ctrl_t;
endpackage : ptc_pkg
`default_nettype wire

// ### verilog/ptc_periodic_tick_counter.sv
// Periodic tick counter with prescaler, limit compare, wrap flag and Wishbone register access.
// Notes on behaviour
// - Match flag in bit 7 sets when count wraps from limit to zero; reset clears it.
// - Writing 1 clears flag and interrupt; writing 0 leaves it alone.
// - Source select 00 low-power, 01 external, 1x internal; reset clears it.
// - Writing a different source select clears prescaler and count.
// - Interrupt asserted while flag set and enable bit 4 is one.
// - Writing a different divider select clears prescaler and count.
// - Divider select zero stops prescaler and counter.
// - Source low bit 0 picks the small binary and decimal ratios.
// - Source low bit 1 picks the large binary and decimal ratios.
// - Count increments per prescaler period, returns to zero after equalling limit.
// - Flag sets on the move from limit to zero only.
// - Limit zero sets the flag on every prescaler output tick.
// - Any limit write clears prescaler and count.
// - Count register is read-only; writes ignored.
// - Reset leaves count zero, limit zero, prescaler off, low-power source.
// - Every limit value 0x00 to 0xFF works as wrap point.
// - Debug halt suspends counting; resume from the held value.
// - Counting continues through processor wait mode.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`default_nettype none
module ptc_periodic_tick_counter
    import ptc_pkg::*;
(
    input  wire logic        core_clk,        // Bus and counter clock.
    input  wire logic        reset,           // Asynchronous reset, active high.
    input  wire logic        wb_cyc_i,        // Wishbone cycle.
    input  wire logic        wb_stb_i,        // Wishbone strobe.
    input  wire logic        wb_we_i,         // Wishbone write enable.
    input  wire logic [3:0]  wb_adr_i,        // Wishbone byte address.
    input  wire logic [3:0]  wb_sel_i,        // Wishbone byte lanes.
    input  wire logic [31:0] wb_dat_i,        // Wishbone write data.
    output logic      [31:0] wb_dat_o,        // Wishbone read data.
    output logic             wb_ack_o,        // Wishbone acknowledge.
    input  wire logic        lowPowerOscClk,  // Low-power oscillator clock.
    input  wire logic        externalRefClk,  // External reference clock.
    input  wire logic        internalRefClk,  // Internal reference clock.
    input  wire logic        debugHalt,       // Processor halted in background debug.
    output logic             tickIrq          // Level interrupt request.
);
    ptc_ctrl_t   ctrl;
    ptc_ctrl_t   next_ctrl;
    logic [7:0]  count;
    logic [7:0]  next_count;
    logic [7:0]  limit;
    logic [7:0]  next_limit;
    logic [17:0] prescale;
    logic [17:0] next_prescale;
    logic [31:0] next_datOut;
    logic        next_ack;
    logic [2:0]  srcEdge;
    logic        selEdge;
    logic [17:0] ratio;
    logic        tick;
    logic        wrap;
    logic        access;
    logic        wrCtrl;
    logic        wrLimit;
    logic        restart;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic [PTC_SYNC_STAGES-1:0] stage;
            logic [PTC_SYNC_STAGES-1:0] next_stage;
            logic                       pinIn;

            // Source pins are ordered low-power, external, internal to match the select codes.
            assign pinIn = (gi == 0) ? lowPowerOscClk : (gi == 1) ? externalRefClk : internalRefClk;

            always_comb begin
                next_stage = {stage[PTC_SYNC_STAGES-2:0], pinIn};
            end

            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    stage <= '0;
                end else begin
                    stage <= next_stage;
                end
            end

            // Only the second and third stages are looked at, keeping the first free of logic.
            assign srcEdge[gi] = stage[1] & ~stage[2];

            AST_SYNC_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (reset) srcEdge[gi] |=> !srcEdge[gi])
                else $error("Source edge lasted more than one cycle.");
        end
    endgenerate

    always_comb begin
        if (ctrl.srcSel[1]) begin
            selEdge = srcEdge[2];
        end else if (ctrl.srcSel == PTC_SRC_EXTERNAL) begin
            selEdge = srcEdge[1];
        end else begin
            selEdge = srcEdge[0];
        end
    end

    assign ratio = ctrl.srcSel[0] ? PTC_RATIO_SRC_LO1[ctrl.divSel] : PTC_RATIO_SRC_LO0[ctrl.divSel];

    assign access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrCtrl  = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == PTC_STATUS_CONTROL_OFFSET);
    assign wrLimit = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == PTC_LIMIT_OFFSET);

    // restart on select change or limit write
    assign restart = wrLimit
                   | (wrCtrl & (wb_dat_i[PTC_SRC_HI_BIT:PTC_SRC_LO_BIT] != ctrl.srcSel))
                   | (wrCtrl & (wb_dat_i[PTC_DIV_HI_BIT:0] != ctrl.divSel));

    // prescaler gating; wait mode does not gate it
    // no wait-mode input exists, so counting runs on through wait.
    // A restart in a tick cycle swallows that tick, so no wrap sets the flag while the count is cleared.
    assign tick = selEdge & ~debugHalt & (ctrl.divSel != PTC_DIV_OFF) & (prescale == ratio - 18'h00001) & ~restart;
    assign wrap = tick & (count == limit);

    always_comb begin
        next_ctrl     = ctrl;
        next_count    = count;
        next_limit    = limit;
        next_prescale = prescale;
        if (selEdge && !debugHalt && ctrl.divSel != PTC_DIV_OFF) begin
            next_prescale = tick ? PTC_PRESCALE_RESET : prescale + 18'h00001;
        end
        if (tick) begin
            next_count = (count == limit) ? PTC_COUNT_RESET : count + 8'h01;
        end
        if (wrCtrl) begin
            next_ctrl.srcSel    = wb_dat_i[PTC_SRC_HI_BIT:PTC_SRC_LO_BIT];
            next_ctrl.irqEnable = wb_dat_i[PTC_IRQ_EN_BIT];
            next_ctrl.divSel    = wb_dat_i[PTC_DIV_HI_BIT:0];
            if (wb_dat_i[PTC_FLAG_BIT]) begin
                next_ctrl.flag = 1'b0;
            end
        end
        if (wrLimit) begin
            next_limit = wb_dat_i[7:0];
        end
        if (restart) begin
            next_prescale = PTC_PRESCALE_RESET;
            next_count    = PTC_COUNT_RESET;
        end
        // a wrap beats a clear in the same cycle
        if (wrap) begin
            next_ctrl.flag = 1'b1;
        end
    end

    // read mux; count writes fall through untouched
    always_comb begin
        next_datOut = 32'h00000000;
        next_ack    = access;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                PTC_STATUS_CONTROL_OFFSET: next_datOut = {24'h000000, ctrl};
                PTC_COUNT_OFFSET:          next_datOut = {24'h000000, count};
                PTC_LIMIT_OFFSET:          next_datOut = {24'h000000, limit};
                default:                   next_datOut = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl     <= '{flag: 1'b0, srcSel: PTC_SRC_RESET, irqEnable: 1'b0, divSel: PTC_DIV_RESET};
            count    <= PTC_COUNT_RESET;
            limit    <= PTC_LIMIT_RESET;
            prescale <= PTC_PRESCALE_RESET;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
        end else begin
            ctrl     <= next_ctrl;
            count    <= next_count;
            limit    <= next_limit;
            prescale <= next_prescale;
            wb_dat_o <= next_datOut;
            wb_ack_o <= next_ack;
        end
    end

    assign tickIrq = ctrl.flag & ctrl.irqEnable;

    default clocking cbAst @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence seqWrapEvent;
        tick && (count == limit);
    endsequence
    sequence seqCleared;
        (count == PTC_COUNT_RESET) && (prescale == PTC_PRESCALE_RESET);
    endsequence
    sequence seqBusTake;
        access;
    endsequence
    sequence seqAckPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    AST_RESET_STATE: assert property ($fell(reset) |-> !ctrl.flag && !ctrl.irqEnable && ctrl.srcSel == PTC_SRC_LOW_POWER && ctrl.divSel == PTC_DIV_OFF && count == PTC_COUNT_RESET && limit == PTC_LIMIT_RESET && prescale == PTC_PRESCALE_RESET)
        else $error("State after reset wrong.");

    AST_FLAG_ON_WRAP: assert property (seqWrapEvent |=> ctrl.flag && count == PTC_COUNT_RESET)
        else $error("Flag or count wrong after wrap.");

    AST_FLAG_W1C: assert property (wrCtrl && wb_dat_i[PTC_FLAG_BIT] && !wrap |=> !ctrl.flag && !tickIrq)
        else $error("Write one did not clear flag.");

    AST_FLAG_W0_KEEPS: assert property (ctrl.flag && wrCtrl && !wb_dat_i[PTC_FLAG_BIT] |=> ctrl.flag)
        else $error("Write zero changed flag.");

    AST_FLAG_STICKY: assert property (ctrl.flag && !(wrCtrl && wb_dat_i[PTC_FLAG_BIT]) |=> ctrl.flag)
        else $error("Flag dropped without a clear.");

    AST_FLAG_ONLY_ON_WRAP: assert property (!ctrl.flag ##1 ctrl.flag |-> $past(wrap))
        else $error("Flag set without wrap.");

    AST_SET_BEATS_CLEAR: assert property (wrap && wrCtrl && wb_dat_i[PTC_FLAG_BIT] |=> ctrl.flag)
        else $error("Clear won over a wrap in the same cycle.");

    AST_READ_CTRL: assert property (access && !wb_we_i && wb_adr_i == PTC_STATUS_CONTROL_OFFSET |=> wb_dat_o == {24'h000000, $past(ctrl)})
        else $error("Control read returned wrong data.");

    AST_IRQ_LEVEL: assert property (tickIrq == (ctrl.flag && ctrl.irqEnable))
        else $error("Interrupt does not follow flag and enable.");

    AST_IRQ_RISE: assert property ($rose(tickIrq) |-> $past(wrap) || ($past(wrCtrl) && $past(wb_dat_i[PTC_IRQ_EN_BIT])))
        else $error("Interrupt rose without wrap or enable write.");

    AST_IRQEN_WRITE_LANDS: assert property (wrCtrl |=> ctrl.irqEnable == $past(wb_dat_i[PTC_IRQ_EN_BIT]))
        else $error("Interrupt enable write lost.");

    AST_SRC_LOW_POWER: assert property (ctrl.srcSel == PTC_SRC_LOW_POWER |-> selEdge == srcEdge[0])
        else $error("Low-power source not selected.");

    AST_SRC_EXTERNAL: assert property (ctrl.srcSel == PTC_SRC_EXTERNAL |-> selEdge == srcEdge[1])
        else $error("External source not selected.");

    AST_SRC_INTERNAL: assert property (ctrl.srcSel[1] |-> selEdge == srcEdge[2])
        else $error("Internal source not selected.");

    AST_SRC_WRITE_LANDS: assert property (wrCtrl |=> ctrl.srcSel == $past(wb_dat_i[PTC_SRC_HI_BIT:PTC_SRC_LO_BIT]))
        else $error("Source select write lost.");

    AST_SRC_CHANGE: assert property (wrCtrl && wb_dat_i[PTC_SRC_HI_BIT:PTC_SRC_LO_BIT] != ctrl.srcSel |=> seqCleared)
        else $error("Source change did not clear counters.");

    AST_SAME_SELECT_KEEPS: assert property (wrCtrl && wb_dat_i[PTC_SRC_HI_BIT:PTC_SRC_LO_BIT] == ctrl.srcSel && wb_dat_i[PTC_DIV_HI_BIT:0] == ctrl.divSel |-> !restart)
        else $error("Rewriting the same selects restarted counting.");

    AST_DIV_CHANGE: assert property (wrCtrl && wb_dat_i[PTC_DIV_HI_BIT:0] != ctrl.divSel |=> seqCleared)
        else $error("Divider change did not clear counters.");

    AST_DIV_WRITE_LANDS: assert property (wrCtrl |=> ctrl.divSel == $past(wb_dat_i[PTC_DIV_HI_BIT:0]))
        else $error("Divider select write lost.");

    AST_LIMIT_WRITE: assert property (wrLimit |=> seqCleared ##0 limit == $past(wb_dat_i[7:0]))
        else $error("Limit write did not clear counters.");

    AST_OFF_HOLDS: assert property (ctrl.divSel == PTC_DIV_OFF && !restart |=> $stable(count))
        else $error("Counter moved while prescaler off.");

    AST_OFF_NO_TICK: assert property (ctrl.divSel == PTC_DIV_OFF |-> !tick)
        else $error("Tick while prescaler off.");

    AST_OFF_PRESCALE_ZERO: assert property (ctrl.divSel == PTC_DIV_OFF |-> prescale == PTC_PRESCALE_RESET)
        else $error("Prescaler not cleared while off.");

    AST_RATIO_LO0_FIRST: assert property (!ctrl.srcSel[0] && ctrl.divSel == 4'h1 |-> ratio == 18'h00008)
        else $error("Ratio for divider one wrong.");

    AST_RATIO_LO0_LAST: assert property (!ctrl.srcSel[0] && ctrl.divSel == 4'hf |-> ratio == 18'h003e8)
        else $error("Ratio for divider fifteen wrong.");

    AST_RATIO_LO1_FIRST: assert property (ctrl.srcSel[0] && ctrl.divSel == 4'h1 |-> ratio == 18'h00400)
        else $error("Large ratio for divider one wrong.");

    AST_RATIO_LO1_LAST: assert property (ctrl.srcSel[0] && ctrl.divSel == 4'hf |-> ratio == 18'h30d40)
        else $error("Large ratio for divider fifteen wrong.");

    AST_PRESCALE_BOUND: assert property (ctrl.divSel != PTC_DIV_OFF |-> prescale < ratio)
        else $error("Prescaler ran past its ratio.");

    AST_PRESCALE_STEP: assert property (selEdge && !debugHalt && ctrl.divSel != PTC_DIV_OFF && !tick && !restart |=> prescale == $past(prescale) + 18'h00001)
        else $error("Prescaler did not step on a source edge.");

    AST_NO_EDGE_HOLDS: assert property (!selEdge && !restart |=> $stable(count) && $stable(prescale))
        else $error("Counting without a source edge.");

    AST_TICK_NEEDS_EDGE: assert property (tick |-> selEdge && !debugHalt)
        else $error("Tick without a source edge.");

    AST_INCREMENT: assert property (tick && count != limit |=> count == $past(count) + 8'h01)
        else $error("Count did not increment.");

    AST_LIMIT_ZERO_WRAPS: assert property (limit == 8'h00 && tick |-> wrap)
        else $error("Zero limit did not wrap on a tick.");

    AST_COUNT_BOUND: assert property (count <= limit)
        else $error("Count passed the limit.");

    AST_READ_LIMIT: assert property (access && !wb_we_i && wb_adr_i == PTC_LIMIT_OFFSET |=> wb_dat_o == {24'h000000, $past(limit)})
        else $error("Limit read returned wrong data.");

    AST_HALT_HOLDS: assert property (debugHalt && !restart |=> $stable(count) && $stable(prescale))
        else $error("Counting during debug halt.");

    AST_HALT_NO_TICK: assert property (debugHalt |-> !tick)
        else $error("Tick during debug halt.");

    AST_COUNT_RO: assert property (access && wb_we_i && wb_adr_i == PTC_COUNT_OFFSET && !tick |=> $stable(count) && $stable(limit) && $stable(ctrl))
        else $error("Count write changed state.");

    AST_READ_COUNT: assert property (access && !wb_we_i && wb_adr_i == PTC_COUNT_OFFSET |=> wb_dat_o == {24'h000000, $past(count)})
        else $error("Count read returned wrong data.");

    AST_READ_UNMAPPED: assert property (access && !wb_we_i && wb_adr_i != PTC_STATUS_CONTROL_OFFSET && wb_adr_i != PTC_COUNT_OFFSET && wb_adr_i != PTC_LIMIT_OFFSET |=> wb_dat_o == 32'h00000000)
        else $error("Unmapped read not zero.");

    AST_WRITE_READS_ZERO: assert property (access && wb_we_i |=> wb_dat_o == 32'h00000000)
        else $error("Write returned nonzero data.");

    AST_ACK_ONE: assert property (seqBusTake |=> seqAckPulse)
        else $error("Bus acknowledge not one cycle.");

    AST_ACK_AFTER_TAKE: assert property (wb_ack_o |-> $past(access))
        else $error("Acknowledge without a request.");
endmodule : ptc_periodic_tick_counter
`default_nettype wire

// ### sim/ptc_periodic_tick_counter_test.sv
// Self-checking Wishbone bench for the periodic tick counter.
`default_nettype none
module ptc_periodic_tick_counter_test
    import ptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [3:0]  adr      = 4'h0;
    logic [3:0]  sel      = 4'h0;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  srcClk   = 3'h0;
    logic        debugHalt = 1'b0;
    logic        tickIrq;
    int          nErrors  = 0;
    int          totalChecks = 0;
    ptc_periodic_tick_counter ptc_periodic_tick_counter_i (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .lowPowerOscClk(srcClk[0]), .externalRefClk(srcClk[1]), .internalRefClk(srcClk[2]),
        .debugHalt(debugHalt), .tickIrq(tickIrq));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : giveVerdict
    task automatic checkVal(input string what, input logic [7:0] expV, input logic [7:0] got);
        totalChecks++;
        if (got !== expV) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", what, expV, got);
        end
    endtask : checkVal
    // The request is held until ack is sampled high; the bench never assumes a latency.
    task automatic wbXfer(input logic isWr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= isWr;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= {24'h0, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            nErrors++;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge core_clk);
    endtask : wbXfer
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        wbXfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] expV);
        logic [7:0] q;
        wbXfer(1'b0, a, 8'h00, q);
        checkVal(what, expV, q);
    endtask : rdChk
    // High phases of four and low phases of five core cycles keep above the three-flop sampling limit.
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge core_clk) srcClk[which] <= 1'b1;
            repeat (4) @(posedge core_clk);
            srcClk[which] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask : pulse
    task automatic cnt(input logic [7:0] e);
        rdChk("count", PTC_COUNT_OFFSET, e);
    endtask : cnt
    task automatic ctl(input logic [7:0] e);
        rdChk("ctrl", PTC_STATUS_CONTROL_OFFSET, e);
    endtask : ctl
    initial begin
        repeat (40000) @(posedge core_clk);
        nErrors++;
        giveVerdict();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        ctl(8'h00);
        cnt(8'h00);
        rdChk("limit", PTC_LIMIT_OFFSET, 8'h00);
        wr(PTC_LIMIT_OFFSET, 8'h03);
        pulse(0, 3);
        cnt(8'h00);
        $display("test reset_and_off done");
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h08);
        pulse(0, 3);
        cnt(8'h03);
        ctl(8'h08);
        pulse(0, 1);
        cnt(8'h00);
        ctl(8'h88);
        checkVal("irq", 8'h00, {7'h0, tickIrq});
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h18);
        checkVal("irq", 8'h01, {7'h0, tickIrq});
        ctl(8'h98);
        pulse(0, 2);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h98);
        ctl(8'h18);
        cnt(8'h02);
        checkVal("irq", 8'h00, {7'h0, tickIrq});
        wr(PTC_COUNT_OFFSET, 8'h55);
        cnt(8'h02);
        rdChk("unmapped", 4'hc, 8'h00);
        $display("test wrap_flag_irq done");
        debugHalt <= 1'b1;
        pulse(0, 2);
        cnt(8'h02);
        debugHalt <= 1'b0;
        pulse(0, 1);
        cnt(8'h03);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h19);
        cnt(8'h00);
        pulse(0, 3);
        cnt(8'h01);
        wr(PTC_LIMIT_OFFSET, 8'h03);
        cnt(8'h00);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h01);
        pulse(0, 15);
        cnt(8'h01);
        pulse(0, 1);
        cnt(8'h02);
        $display("test halt_and_ratios done");
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h48);
        cnt(8'h00);
        pulse(0, 2);
        pulse(1, 2);
        cnt(8'h00);
        pulse(2, 2);
        cnt(8'h02);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h28);
        pulse(1, 999);
        cnt(8'h00);
        pulse(1, 1);
        cnt(8'h01);
        $display("test sources done");
        wr(PTC_LIMIT_OFFSET, 8'h00);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h08);
        pulse(0, 1);
        ctl(8'h88);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h88);
        pulse(0, 1);
        ctl(8'h88);
        cnt(8'h00);
        wr(PTC_STATUS_CONTROL_OFFSET, 8'h88);
        wr(PTC_LIMIT_OFFSET, 8'hff);
        pulse(0, 255);
        cnt(8'hff);
        ctl(8'h08);
        pulse(0, 1);
        cnt(8'h00);
        ctl(8'h88);
        @(posedge core_clk) reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        ctl(8'h00);
        cnt(8'h00);
        rdChk("limit", PTC_LIMIT_OFFSET, 8'h00);
        $display("test limits_and_rereset done");
        giveVerdict();
    end
endmodule : ptc_periodic_tick_counter_test
`default_nettype wire
